// [src/wbm_menu.sv]
/*
  workbench service menu and bus address entry: item navigation,
  calibration capture, factory restore, online, language, rotation,
  7-bit address entry through four leds.
  assumes measurement values are valid words sampled on capture.
*/
`timescale 1ns/1ps
module wbm_menu
  import wbm_pkg::*;
#(
  parameter int DEB_CYC = DEBOUNCE_CYC,
  parameter int PWM_CYC = BLINK_CYC,
  parameter int REP_START = REP_START_CYC,
  parameter int REP_IVL = REP_IVL_CYC,
  parameter int REP_BIG_N = REP_BIG_COUNT,
  parameter logic [6:0] BIG_STEP = REP_BIG_STEP,
  parameter int MEAS_W = 16
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // keys, active high
  input wire logic key_menu,
  input wire logic key_up,
  input wire logic key_down,
  // variant straps
  input wire logic analog_variant,
  input wire logic has_text_display,
  input wire logic first_startup,
  // measurements
  input wire logic [MEAS_W-1:0] meas_current,
  input wire logic [MEAS_W-1:0] meas_position,
  // adaptation status
  input wire logic adapt_done,
  // leds, index 0 is the menu key led
  output logic [4:0] led,
  // calibration points
  output logic [MEAS_W-1:0] cal_4ma_ff,
  output logic [MEAS_W-1:0] cal_20ma_ff,
  output logic [MEAS_W-1:0] cal_neg45_ff,
  output logic [MEAS_W-1:0] cal_pos45_ff,
  // configuration
  output logic double_acting_ff,
  output logic [1:0] language_ff,
  output logic rotated_ff,
  output logic online_ff,
  output logic [6:0] bus_addr_ff,
  // text display of address
  output logic [7:0] addr_dec_bcd_hi_ff,
  output logic [7:0] addr_dec_bcd_lo_ff,
  output logic [7:0] addr_hex_ff,
  output logic addr_text_valid_ff,
  // command pulses and current item
  output wbm_cmd_type cmd_ff,
  output wbm_item_type item
);
  // ****************************************
  // factory defaults
  // ****************************************
  localparam logic [MEAS_W-1:0] CAL_4MA_DEF = '0;
  localparam logic [MEAS_W-1:0] CAL_20MA_DEF = '1;
  localparam logic [MEAS_W-1:0] CAL_NEG_DEF = '0;
  localparam logic [MEAS_W-1:0] CAL_POS_DEF = '1;

  // ****************************************
  // helpers
  // ****************************************
  // wrap add or subtract within seven bits
  function automatic logic [6:0] addr_step(input logic [6:0] a,
                                           input logic [6:0] d,
                                           input logic up);
    logic [7:0] s;
    s = '0;
    if (up) begin
      s = {1'b0, a} + {1'b0, d};
    end else begin
      s = {1'b0, a} - {1'b0, d};
    end
    return s[6:0];
  endfunction

  // next item for menu key
  function automatic wbm_item_type next_item(input wbm_item_type i,
                                             input logic analog);
    case (i)
      IT_TOP: next_item = analog ? IT_CAL_LO : IT_ANG_NEG;
      IT_CAL_LO: next_item = IT_CAL_HI;
      IT_CAL_HI: next_item = IT_ANG_NEG;
      IT_ANG_NEG: next_item = IT_ANG_POS;
      IT_ANG_POS: next_item = IT_RST_SINGLE;
      IT_RST_SINGLE: next_item = IT_RST_DOUBLE;
      IT_RST_DOUBLE: next_item = IT_GO_ONLINE;
      IT_GO_ONLINE: next_item = IT_LANG;
      IT_LANG: next_item = IT_ROT;
      IT_ROT: next_item = analog ? IT_TOP : IT_ADDR_MENU;
      IT_ADDR_MENU: next_item = IT_ADDR_LO;
      IT_ADDR_LO: next_item = IT_ADDR_WHOLE;
      IT_ADDR_HI: next_item = IT_ADDR_WHOLE;
      default: next_item = IT_TOP;
    endcase
  endfunction

  // ****************************************
  // keys
  // ****************************************
  wbm_keys_type keys; // filtered key events
  wbm_key_filter #(
    .STABLE_CYC(DEB_CYC)
  ) u_keys (
    .clock(clock),
    .arst_n(arst_n),
    .key_menu(key_menu),
    .key_up(key_up),
    .key_down(key_down),
    .keys(keys)
  );

  // ****************************************
  // navigation
  // ****************************************
  wbm_item_type item_ff; // current menu item
  logic first_ff; // first start sequence pending
  logic strap_seen_ff; // strap captured after release
  logic adapt_started_ff; // adaptation requested once
  logic [6:0] edit_addr_ff; // address being entered
  assign item = item_ff;

  // strap capture after reset release
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      strap_seen_ff <= 1'b0;
      first_ff <= 1'b0;
    end else if (!strap_seen_ff) begin
      strap_seen_ff <= 1'b1;
      first_ff <= first_startup;
    end else if (item_ff == IT_LANG && (keys.menu || keys.both)) begin
      first_ff <= 1'b0;
    end
  end

  // item state machine
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      item_ff <= IT_TOP;
    end else if (!strap_seen_ff) begin
      if (first_startup) begin
        item_ff <= IT_GO_ONLINE;
      end
    end else if (keys.menu) begin
      if (first_ff && item_ff == IT_LANG) begin
        item_ff <= IT_TOP;
      end else begin
        item_ff <= next_item(item_ff, analog_variant);
      end
    end else if (item_ff == IT_ADDR_LO && (keys.up || keys.down)) begin
      item_ff <= IT_ADDR_HI;
    end else if (item_ff == IT_ADDR_MENU && keys.both) begin
      item_ff <= IT_ADDR_LO;
    end else if (first_ff && item_ff == IT_GO_ONLINE && keys.both) begin
      item_ff <= IT_LANG;
    end
  end

  // ****************************************
  // calibration and restore
  // ****************************************
  logic restore; // either factory restore taken
  logic in_cur; // current item allowed
  assign in_cur = analog_variant;
  assign restore = keys.both &&
                   (item_ff == IT_RST_SINGLE || item_ff == IT_RST_DOUBLE);

  // calibration points
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cal_4ma_ff <= CAL_4MA_DEF;
      cal_20ma_ff <= CAL_20MA_DEF;
      cal_neg45_ff <= CAL_NEG_DEF;
      cal_pos45_ff <= CAL_POS_DEF;
    end else if (restore) begin
      cal_4ma_ff <= CAL_4MA_DEF;
      cal_20ma_ff <= CAL_20MA_DEF;
      cal_neg45_ff <= CAL_NEG_DEF;
      cal_pos45_ff <= CAL_POS_DEF;
    end else if (keys.both) begin
      case (item_ff)
        IT_CAL_LO: if (in_cur) cal_4ma_ff <= meas_current;
        IT_CAL_HI: if (in_cur) cal_20ma_ff <= meas_current;
        IT_ANG_NEG: cal_neg45_ff <= meas_position;
        IT_ANG_POS: cal_pos45_ff <= meas_position;
        default: cal_4ma_ff <= cal_4ma_ff;
      endcase
    end
  end

  // pneumatic output type
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      double_acting_ff <= 1'b0;
    end else if (keys.both && item_ff == IT_RST_SINGLE) begin
      double_acting_ff <= 1'b0;
    end else if (keys.both && item_ff == IT_RST_DOUBLE) begin
      double_acting_ff <= 1'b1;
    end
  end

  // command pulses
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cmd_ff <= '0;
    end else begin
      cmd_ff <= '0;
      cmd_ff.store_lo <= keys.both && in_cur && item_ff == IT_CAL_LO;
      cmd_ff.store_hi <= keys.both && in_cur && item_ff == IT_CAL_HI;
      cmd_ff.store_neg <= keys.both && item_ff == IT_ANG_NEG;
      cmd_ff.store_pos <= keys.both && item_ff == IT_ANG_POS;
      cmd_ff.restore_single <= keys.both && item_ff == IT_RST_SINGLE;
      cmd_ff.restore_double <= keys.both && item_ff == IT_RST_DOUBLE;
      cmd_ff.restore_all_cal <= restore;
      cmd_ff.go_online <= keys.both && item_ff == IT_GO_ONLINE;
      cmd_ff.start_adapt <= strap_seen_ff && !online_ff && first_ff &&
                            !adapt_started_ff;
    end
  end

  // ****************************************
  // online and adaptation
  // ****************************************
  // online after adaptation or directly from service item
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      online_ff <= 1'b0;
      adapt_started_ff <= 1'b0;
    end else begin
      if (strap_seen_ff && first_ff && !online_ff) begin
        adapt_started_ff <= 1'b1;
      end
      if (restore) begin
        online_ff <= 1'b0;
      end else if (keys.both && item_ff == IT_GO_ONLINE) begin
        online_ff <= 1'b1;
      end else if (adapt_started_ff && adapt_done) begin
        online_ff <= 1'b1;
      end
    end
  end

  // ****************************************
  // language and rotation
  // ****************************************
  // up and down cycle, allowed any time
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      language_ff <= LANG_ENGLISH;
      rotated_ff <= 1'b0;
    end else begin
      if (item_ff == IT_LANG && keys.up) begin
        language_ff <= (language_ff == LANG_LAST) ? LANG_ENGLISH :
                       language_ff + 2'h1;
      end else if (item_ff == IT_LANG && keys.down) begin
        language_ff <= (language_ff == LANG_ENGLISH) ? LANG_LAST :
                       language_ff - 2'h1;
      end
      if (item_ff == IT_ROT && (keys.up || keys.down)) begin
        rotated_ff <= ~rotated_ff;
      end
    end
  end

  // ****************************************
  // address entry
  // ****************************************
  logic [31:0] rep_cnt_ff; // hold timer
  logic [7:0] rep_n_ff; // repeats done
  logic rep_fire; // auto-repeat step now
  logic held; // whole entry key held
  logic [6:0] hi_step; // upper bits moved by one, wrapped below
  assign hi_step = addr_step({4'h0, edit_addr_ff[6:4]}, 7'h01, keys.up);
  assign held = item_ff == IT_ADDR_WHOLE &&
                (keys.up_held || keys.down_held);
  assign rep_fire = held && rep_cnt_ff >= 32'(REP_START - 1);

  // auto-repeat timer
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rep_cnt_ff <= '0;
      rep_n_ff <= '0;
    end else if (!held) begin
      rep_cnt_ff <= '0;
      rep_n_ff <= '0;
    end else if (rep_fire) begin
      rep_cnt_ff <= 32'(REP_START - REP_IVL);
      if (rep_n_ff != 8'hFF) begin
        rep_n_ff <= rep_n_ff + 8'h1;
      end
    end else begin
      rep_cnt_ff <= rep_cnt_ff + 32'h1;
    end
  end

  // edit value and active address
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      edit_addr_ff <= ADDR_DEFAULT;
      bus_addr_ff <= ADDR_DEFAULT;
    end else begin
      case (item_ff)
        IT_ADDR_MENU: edit_addr_ff <= bus_addr_ff;
        IT_ADDR_HI: begin
          if (keys.up || keys.down) begin
            edit_addr_ff[6:4] <= hi_step[2:0];
          end
        end
        IT_ADDR_WHOLE: begin
          if (rep_fire) begin
            edit_addr_ff <= addr_step(edit_addr_ff,
                            (rep_n_ff >= 8'(REP_BIG_N)) ? BIG_STEP : 7'h01,
                            keys.up_held);
          end else if (keys.up || keys.down) begin
            edit_addr_ff <= addr_step(edit_addr_ff, 7'h01, keys.up);
          end
        end
        default: edit_addr_ff <= edit_addr_ff;
      endcase
      if (keys.both && (item_ff == IT_ADDR_LO || item_ff == IT_ADDR_HI ||
                        item_ff == IT_ADDR_WHOLE)) begin
        bus_addr_ff <= edit_addr_ff;
      end
    end
  end

  // text form of entered address
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      addr_dec_bcd_hi_ff <= '0;
      addr_dec_bcd_lo_ff <= '0;
      addr_hex_ff <= '0;
      addr_text_valid_ff <= 1'b0;
    end else begin
      addr_dec_bcd_hi_ff <= 8'(edit_addr_ff / 7'd100);
      addr_dec_bcd_lo_ff <= {4'(((edit_addr_ff % 7'd100) / 7'd10)),
                             4'(edit_addr_ff % 7'd10)};
      addr_hex_ff <= {1'b0, edit_addr_ff};
      addr_text_valid_ff <= has_text_display;
    end
  end

  // ****************************************
  // leds
  // ****************************************
  wbm_duty_type duty [5]; // per led duty code
  // item pattern selection
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      duty[i] = LED_OFF;
    end
    case (item_ff)
      IT_CAL_LO: duty[2] = LED_ON;
      IT_CAL_HI: begin
        duty[1] = LED_ON;
        duty[2] = LED_ON;
      end
      IT_ANG_NEG: duty[3] = LED_ON;
      IT_ANG_POS: begin
        duty[1] = LED_ON;
        duty[3] = LED_ON;
      end
      IT_RST_SINGLE: duty[4] = LED_ON;
      IT_RST_DOUBLE: begin
        duty[1] = LED_ON;
        duty[4] = LED_ON;
      end
      IT_ADDR_MENU: begin
        duty[0] = LED_HALF;
        duty[3] = LED_HALF;
        duty[4] = LED_HALF;
      end
      IT_ADDR_LO: begin
        duty[0] = LED_QUARTER;
        duty[1] = LED_THREEQ;
      end
      IT_ADDR_HI: begin
        duty[0] = LED_QUARTER;
        duty[4] = LED_THREEQ;
      end
      default: duty[0] = LED_OFF;
    endcase
  end

  logic [4:0] pwm_led; // blink levels
  wbm_led_pwm #(
    .PERIOD_CYC(PWM_CYC)
  ) u_pwm (
    .clock(clock),
    .arst_n(arst_n),
    .duty(duty),
    .led(pwm_led)
  );

  // nibble shown on leds 1..4 while up or down is held in lower or upper entry
  always_comb begin
    led = pwm_led;
    if (item_ff == IT_ADDR_LO && (keys.up_held || keys.down_held)) begin
      led[4:1] = edit_addr_ff[3:0];
    end else if (item_ff == IT_ADDR_HI &&
                 (keys.up_held || keys.down_held)) begin
      led[4:1] = {1'b0, edit_addr_ff[6:4]};
    end
  end
endmodule // wbm_menu

// [src/wbm_pkg.sv]
/*
  package of the workbench menu and address entry block: item codes,
  led patterns, timing counts and carrier structs.
  assumes one 250 MHz clock and keys already synchronous to it.
*/
package wbm_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 250; // clock rate
  localparam int DEBOUNCE_US = 10; // key must stay stable this long
  localparam int DEBOUNCE_CYC = DEBOUNCE_US * CLK_MHZ;
  localparam int BLINK_US = 2000; // one blink period
  localparam int BLINK_CYC = BLINK_US * CLK_MHZ;
  localparam int REP_START_US = 500000; // hold before auto-repeat
  localparam int REP_START_CYC = REP_START_US * CLK_MHZ;
  localparam int REP_IVL_US = 100000; // auto-repeat interval
  localparam int REP_IVL_CYC = REP_IVL_US * CLK_MHZ;
  localparam int REP_BIG_COUNT = 8; // repeats before big steps
  localparam logic [6:0] REP_BIG_STEP = 7'h0A; // large increment
  // ****************************************
  // values
  // ****************************************
  localparam logic [6:0] ADDR_DEFAULT = 7'h7E; // delivered address
  localparam logic [6:0] ADDR_MAX = 7'h7F; // top of address range
  localparam logic [1:0] LANG_ENGLISH = 2'h0; // factory language
  localparam logic [1:0] LANG_LAST = 2'h2; // third language
  // ****************************************
  // led duty codes
  // ****************************************
  typedef enum logic [2:0] {
    LED_OFF = 3'b000,
    LED_ON = 3'b001,
    LED_QUARTER = 3'b010,
    LED_HALF = 3'b011,
    LED_THREEQ = 3'b100
  } wbm_duty_type;
  // ****************************************
  // menu items
  // ****************************************
  typedef enum logic [3:0] {
    IT_TOP = 4'b0000,
    IT_CAL_LO = 4'b0001,
    IT_CAL_HI = 4'b0010,
    IT_ANG_NEG = 4'b0011,
    IT_ANG_POS = 4'b0100,
    IT_RST_SINGLE = 4'b0101,
    IT_RST_DOUBLE = 4'b0110,
    IT_GO_ONLINE = 4'b0111,
    IT_LANG = 4'b1000,
    IT_ROT = 4'b1001,
    IT_ADDR_MENU = 4'b1010,
    IT_ADDR_LO = 4'b1011,
    IT_ADDR_HI = 4'b1100,
    IT_ADDR_WHOLE = 4'b1101
  } wbm_item_type;
  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic menu; // menu key pulse
    logic up; // up key pulse (alone)
    logic down; // down key pulse (alone)
    logic both; // combined up+down pulse
    logic up_held; // up stable pressed level
    logic down_held; // down stable pressed level
  } wbm_keys_type;
  typedef struct packed {
    logic store_lo; // capture current as 4 mA
    logic store_hi; // capture current as 20 mA
    logic store_neg; // capture position as -45 deg
    logic store_pos; // capture position as +45 deg
    logic restore_single; // factory set, single acting
    logic restore_double; // factory set, double acting
    logic restore_all_cal; // every calibration to default
    logic go_online; // online without adaptation
    logic start_adapt; // run self adaptation
  } wbm_cmd_type;
endpackage

// [src/wbm_key_filter.sv]
/*
  key debouncer and combiner for menu, up and down keys.
  assumes keys are active high levels synchronous to the clock.
*/
`timescale 1ns/1ps
module wbm_key_filter
  import wbm_pkg::*;
#(
  parameter int STABLE_CYC = DEBOUNCE_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // raw keys
  input wire logic key_menu,
  input wire logic key_up,
  input wire logic key_down,
  // filtered keys
  output wbm_keys_type keys
);
  // ****************************************
  // debounce
  // ****************************************
  logic [2:0] raw; // raw key vector
  logic [2:0] stable_ff; // debounced levels
  logic [2:0] prev_ff; // last debounced levels
  logic [31:0] cnt_ff [3]; // stability counters
  logic both_seen_ff; // combined press already issued
  logic any_ud; // up or down pressed
  assign raw = {key_down, key_up, key_menu};

  // per key stability counter
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 3; i++) begin
        cnt_ff[i] <= '0;
      end
      stable_ff <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (raw[i] == stable_ff[i]) begin
          cnt_ff[i] <= '0;
        end else if (cnt_ff[i] >= 32'(STABLE_CYC - 1)) begin
          cnt_ff[i] <= '0;
          stable_ff[i] <= raw[i];
        end else begin
          cnt_ff[i] <= cnt_ff[i] + 32'h1;
        end
      end
    end
  end

  // edge history and combined press lock
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      prev_ff <= '0;
      both_seen_ff <= 1'b0;
    end else begin
      prev_ff <= stable_ff;
      if (stable_ff[1] && stable_ff[2]) begin
        both_seen_ff <= 1'b1;
      end else if (!any_ud) begin
        both_seen_ff <= 1'b0;
      end
    end
  end
  assign any_ud = stable_ff[1] | stable_ff[2];

  // up and down events fire on release, menu on press, so a pair is never split
  always_comb begin
    keys.menu = stable_ff[0] & ~prev_ff[0];
    keys.both = stable_ff[1] & stable_ff[2] & ~both_seen_ff;
    keys.up = prev_ff[1] & ~stable_ff[1] & ~stable_ff[2] & ~both_seen_ff;
    keys.down = prev_ff[2] & ~stable_ff[2] & ~stable_ff[1] & ~both_seen_ff;
    keys.up_held = stable_ff[1] & ~stable_ff[2] & ~both_seen_ff;
    keys.down_held = stable_ff[2] & ~stable_ff[1] & ~both_seen_ff;
  end
endmodule // wbm_key_filter

// [src/wbm_led_pwm.sv]
/*
  blink generator: turns a duty code into an led level.
  assumes a free running phase counter shared by all leds.
*/
`timescale 1ns/1ps
module wbm_led_pwm
  import wbm_pkg::*;
#(
  parameter int PERIOD_CYC = BLINK_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // duty codes, index 0 is the menu key led
  input wbm_duty_type duty [5],
  // led levels
  output logic [4:0] led
);
  logic [31:0] phase_ff; // position inside blink period
  logic [4:0] nxt_led; // next led levels

  // phase counter wraps once per period
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase_ff <= '0;
    end else if (phase_ff >= 32'(PERIOD_CYC - 1)) begin
      phase_ff <= '0;
    end else begin
      phase_ff <= phase_ff + 32'h1;
    end
  end

  // duty compare per led
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      case (duty[i])
        LED_ON: nxt_led[i] = 1'b1;
        LED_QUARTER: nxt_led[i] = phase_ff < 32'(PERIOD_CYC / 4);
        LED_HALF: nxt_led[i] = phase_ff < 32'(PERIOD_CYC / 2);
        LED_THREEQ: nxt_led[i] = phase_ff < 32'((PERIOD_CYC * 3) / 4);
        default: nxt_led[i] = 1'b0;
      endcase
    end
  end

  // registered led outputs
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      led <= '0;
    end else begin
      led <= nxt_led;
    end
  end
endmodule // wbm_led_pwm

// [test/wbm_menu_asserts.sv]
/*
  checker of the menu block: captures, restores, online, language.
  assumes it is bound to wbm_menu and sees only its ports.
*/
`timescale 1ns/1ps
module wbm_menu_asserts
  import wbm_pkg::*;
#(parameter int MEAS_W = 16) (
  // clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // inputs seen
  input wire logic analog_variant,
  input wire logic [MEAS_W-1:0] meas_current,
  input wire logic [MEAS_W-1:0] meas_position,
  // outputs seen
  input wire logic [MEAS_W-1:0] cal_4ma_ff,
  input wire logic [MEAS_W-1:0] cal_20ma_ff,
  input wire logic [MEAS_W-1:0] cal_neg45_ff,
  input wire logic [MEAS_W-1:0] cal_pos45_ff,
  input wire logic double_acting_ff,
  input wire logic [1:0] language_ff,
  input wire logic online_ff,
  input wire wbm_cmd_type cmd_ff
);
  // ****************************************
  // properties
  // ****************************************
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  property p_lo; cmd_ff.store_lo |-> cal_4ma_ff == $past(meas_current);
  endproperty
  property p_hi; cmd_ff.store_hi |-> cal_20ma_ff == $past(meas_current);
  endproperty
  property p_neg; cmd_ff.store_neg |-> cal_neg45_ff == $past(meas_position);
  endproperty
  property p_pos; cmd_ff.store_pos |-> cal_pos45_ff == $past(meas_position);
  endproperty
  property p_ana; cmd_ff.store_lo || cmd_ff.store_hi |-> analog_variant;
  endproperty
  property p_sgl; cmd_ff.restore_single |-> !double_acting_ff; endproperty
  property p_dbl; cmd_ff.restore_double |-> double_acting_ff; endproperty
  property p_all;
    cmd_ff.restore_single || cmd_ff.restore_double |-> cmd_ff.restore_all_cal;
  endproperty
  property p_onl; cmd_ff.go_online |-> ##[0:1] online_ff; endproperty
  property p_lang; language_ff <= LANG_LAST; endproperty
  a_lo: assert property (p_lo) else $error("4 mA point wrong");
  a_hi: assert property (p_hi) else $error("20 mA point wrong");
  a_neg: assert property (p_neg) else $error("neg point wrong");
  a_pos: assert property (p_pos) else $error("pos point wrong");
  a_ana: assert property (p_ana) else $error("capture off");
  a_sgl: assert property (p_sgl) else $error("single wrong");
  a_dbl: assert property (p_dbl) else $error("double wrong");
  a_all: assert property (p_all) else $error("cal kept");
  a_onl: assert property (p_onl) else $error("not online");
  a_lang: assert property (p_lang) else $error("bad lang");
  // main scenarios reached
  c_neg: cover property (cmd_ff.store_neg);
  c_dbl: cover property (cmd_ff.restore_double);
  c_onl: cover property (cmd_ff.go_online);
endmodule // wbm_menu_asserts

bind wbm_menu wbm_menu_asserts #(.MEAS_W(MEAS_W)) wbm_menu_asserts_inst (
  .clock(clock), .arst_n(arst_n), .analog_variant(analog_variant),
  .meas_current(meas_current), .meas_position(meas_position),
  .cal_4ma_ff(cal_4ma_ff), .cal_20ma_ff(cal_20ma_ff),
  .cal_neg45_ff(cal_neg45_ff), .cal_pos45_ff(cal_pos45_ff),
  .double_acting_ff(double_acting_ff), .language_ff(language_ff),
  .online_ff(online_ff), .cmd_ff(cmd_ff));

// [test/wbm_operator.sv]
/*
  operator model: presses key chords long enough to pass debounce.
  assumes a debounce of a few cycles and keys sampled on the clock.
*/
`timescale 1ns/1ps
module wbm_operator (
  // clock
  input wire logic clock,
  // key levels, active high
  output logic key_menu,
  output logic key_up,
  output logic key_down
);
  // keys released at time zero
  initial {key_menu, key_up, key_down} = 3'h0;
  // chord held together, then released and left to settle
  task automatic press(input logic [2:0] k);
    @(posedge clock);
    #1 {key_menu, key_up, key_down} = k;
    repeat (8) @(posedge clock);
    #1 {key_menu, key_up, key_down} = 3'h0;
    repeat (8) @(posedge clock);
  endtask
endmodule // wbm_operator

// [test/wbm_menu_tb.sv]
/*
  testbench of the menu block: walks every item, then the address entry.
  assumes the operator model and the bound checker.
*/
`timescale 1ns/1ps
module wbm_menu_tb;
  import wbm_pkg::*;
  logic clock = 1'b0, arst_n, analog_variant;
  logic key_menu, key_up, key_down, adapt_done;
  logic has_text_display, first_startup;
  logic [15:0] meas_current, meas_position;
  logic [15:0] cal_4ma_ff, cal_20ma_ff, cal_neg45_ff, cal_pos45_ff;
  logic [15:0] cur, pos;
  logic [7:0] addr_dec_bcd_hi_ff, addr_dec_bcd_lo_ff, addr_hex_ff;
  logic [6:0] bus_addr_ff;
  logic [4:0] led;
  logic [1:0] language_ff;
  logic double_acting_ff, rotated_ff, online_ff, addr_text_valid_ff;
  wbm_cmd_type cmd_ff;
  wbm_item_type item;
  int n_mismatch = 0, checked = 0;
  // free running clock
  always #2 clock = ~clock;
  wbm_operator wbm_operator_inst (.*);
  wbm_menu #(.DEB_CYC(4), .PWM_CYC(16), .REP_START(20), .REP_IVL(5))
    wbm_menu_inst (.*);
  // compare and count
  task automatic chk(input string w, input logic [15:0] e, g);
    checked++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
      n_mismatch++;
    end
  endtask
  // verdict and end of run
  task automatic report_and_stop;
    $display("counts: %0d checked, %0d mismatched", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // five cycles of reset, then let straps settle
  task automatic do_reset(input logic ana, fs);
    #1 arst_n = 1'b0;
    analog_variant = ana;
    first_startup = fs;
    repeat (5) @(posedge clock);
    #1 arst_n = 1'b1;
    repeat (2) @(posedge clock);
  endtask
  // one blink period of leds a and b, five count bits each
  task automatic led_sum(input string w, input int a, b,
                         input logic [15:0] e);
    int n;
    n = 0;
    repeat (16) begin
      @(posedge clock);
      #1 n += led[a] + 32 * led[b];
    end
    chk(w, e, 16'(n));
  endtask
  // expected effect of the chord, or of the up press in items 8 and 9, in item i
  function automatic logic [15:0] want(int i);
    return (i < 3) ? cur : (i < 5) ? pos : (i == 5) ? 16'h0 : 16'h1;
  endfunction
  // observed effect in item i
  function automatic logic [15:0] seen(int i);
    case (i)
      1: return cal_4ma_ff;
      2: return cal_20ma_ff;
      3: return cal_neg45_ff;
      4: return cal_pos45_ff;
      5, 6: return {15'h0, double_acting_ff};
      7: return {15'h0, online_ff};
      8: return {14'h0, language_ff};
      default: return {15'h0, rotated_ff};
    endcase
  endfunction
  initial begin
    void'($urandom(32'h7CCB726E));
    {arst_n, adapt_done, first_startup} = 3'h0;
    has_text_display = 1'($urandom);
    do_reset(1'b1, 1'b0);
    chk("language", 16'h0, {14'h0, language_ff});
    for (int i = 1; i <= 10; i++) begin
      cur = 16'($urandom);
      pos = 16'($urandom);
      meas_current = cur;
      meas_position = pos;
      wbm_operator_inst.press(3'h4);
      chk("item", 16'(i % 10), {12'h0, item});
      if (i < 10) wbm_operator_inst.press((i < 8) ? 3'h3 : 3'h2);
      if (i < 10) chk("effect", want(i), seen(i));
      $display("item test %0d done", i);
    end
    do_reset(1'b0, 1'b0);
    for (int k = 0; k < 12 && item !== IT_ADDR_MENU; k++)
      wbm_operator_inst.press(3'h4);
    chk("address menu", 16'(IT_ADDR_MENU), {12'h0, item});
    led_sum("menu led3", 0, 3, 16'h0108);
    led_sum("led4 led1", 4, 1, 16'h0008);
    wbm_operator_inst.press(3'h3);
    led_sum("lower", 0, 1, 16'h0184);
    wbm_operator_inst.press(3'h2);
    led_sum("upper", 0, 4, 16'h0184);
    wbm_operator_inst.press(3'h2);
    chk("pending", 16'h7E, {9'h0, bus_addr_ff});
    wbm_operator_inst.press(3'h3);
    chk("active", 16'h0E, {9'h0, bus_addr_ff});
    wbm_operator_inst.press(3'h4);
    wbm_operator_inst.press(3'h2);
    chk("hex", 16'h0F, {8'h0, addr_hex_ff});
    chk("dec", 16'h15, {addr_dec_bcd_hi_ff, addr_dec_bcd_lo_ff});
    chk("text", 16'(has_text_display), 16'(addr_text_valid_ff));
    $display("address test done");
    do_reset(1'b0, 1'b1);
    #1 adapt_done = 1'b1;
    chk("first item", 16'(IT_GO_ONLINE), {12'h0, item});
    chk("early online", 16'h0, 16'(online_ff));
    repeat (2) @(posedge clock);
    #1 chk("adapted", 16'h1, 16'(online_ff));
    $display("first startup test done");
    report_and_stop();
  end
endmodule // wbm_menu_tb
